/* File: rtl/cms_clock_mode_ctrl.sv */
// clock mode select controller: strap decode, clock routing and frequency control register
// Summary of operation
// - straps 000..100 and 111 pick clock mode
// - frequency register initialised only by reset pin
// - watchdog power-on reset keeps register contents
// - mode 0: ext clock, PLL2 x1, PLL1 on
// - mode 1: ext clock, PLL2 x4, bus clock out
// - mode 2: crystal, PLL2 x4, PLL1 on
// - mode 3: ext clock x1, PLL1 software switched
// - mode 4: crystal x1, PLL1 software switched
// - modes 3/4: divider 1 source follows PLL1 state, divider 2 stays on PLL2
// - mode 7: bus clock input, PLL2 off
// - other modes drive bus clock out
// - driven bus clock may be held fixed
// - register holds output, PLL and divider controls
// - PLL1 aligns internal edge to bus clock
`timescale 1ns/100ps
module cms_clock_mode_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wdt_poweron_reset,
  // mode straps
  input wire logic mode_strap_bit0,
  input wire logic mode_strap_bit1,
  input wire logic mode_strap_bit2,
  // avalon-mm slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // bus clock pin
  input wire logic bus_clock_io_in,
  output logic bus_clock_io_out,
  output logic bus_clock_io_oe,
  // clock generator controls
  output logic [2:0] clock_mode,
  output logic mode_valid,
  output logic mode_illegal,
  output logic crystal_osc_enable,
  output logic ext_clock_select,
  output logic pll2_enable,
  output logic pll2_ratio_x4,
  output logic pll1_enable,
  output logic [1:0] pll1_ratio,
  output logic pll1_ref_bus_clock,
  output logic pll_standby,
  output logic div1_src_pll1,
  output logic div2_src_pll1,
  output logic div3_enable,
  output logic [1:0] internal_div,
  output logic [1:0] periph_div
);
  cms_pkg::cms_mode_t mode;
  logic strap_valid;
  logic strap_illegal;
  logic [15:0] freq_control_reg;
  logic bus_in_meta;
  logic bus_in_sync;
  logic bus_clk_level;

  cms_strap_capture u_strap (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .recapture(wdt_poweron_reset),
    .mode_strap_bit0(mode_strap_bit0),
    .mode_strap_bit1(mode_strap_bit1),
    .mode_strap_bit2(mode_strap_bit2),
    .mode(mode),
    .mode_valid(strap_valid),
    .mode_illegal(strap_illegal)
  );

  // bus decode
  wire hit_freq = (avs_address == cms_pkg::ADDR_FREQ_CTRL);
  wire hit_status = (avs_address == cms_pkg::ADDR_MODE_STATUS);
  wire access_ack = (avs_read || avs_write) && !avs_waitrequest;
  wire do_write = avs_write && !avs_waitrequest && hit_freq;

  // mode classes
  wire m_fixed_pll1 = strap_valid && (mode == cms_pkg::CMS_MODE0 || mode == cms_pkg::CMS_MODE1 ||
                                      mode == cms_pkg::CMS_MODE2);
  wire m_sw_pll1 = strap_valid && (mode == cms_pkg::CMS_MODE3 || mode == cms_pkg::CMS_MODE4);
  wire m_bus_in = strap_valid && (mode == cms_pkg::CMS_MODE7);
  wire next_pll1_en = m_fixed_pll1 || m_bus_in || (m_sw_pll1 && freq_control_reg[cms_pkg::BIT_PLL1_ON]);
  wire next_bus_oe = strap_valid && !m_bus_in;
  wire bus_hold = !freq_control_reg[cms_pkg::BIT_BUS_CLK_OUT];
  wire next_pll2_x4 = strap_valid && (mode == cms_pkg::CMS_MODE1 || mode == cms_pkg::CMS_MODE2);
  wire next_crystal_drive_out = strap_valid && (mode == cms_pkg::CMS_MODE2 || mode == cms_pkg::CMS_MODE4);
  wire next_ext = strap_valid && (mode == cms_pkg::CMS_MODE0 || mode == cms_pkg::CMS_MODE1 ||
                                  mode == cms_pkg::CMS_MODE3);

  wire [15:0] freq_wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] next_freq = (freq_control_reg & ~freq_wmask) | (avs_writedata[15:0] & freq_wmask);

  wire [7:0] status_word = {bus_in_sync, bus_clock_io_oe, pll1_enable, strap_illegal, strap_valid, mode};
  wire [31:0] next_readdata = hit_freq ? {16'h0000, freq_control_reg} :
                              hit_status ? {24'h00_0000, status_word} : 32'h0000_0000;

  // avalon slave: one wait state, read data registered with the answer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= next_readdata;
      end else if (access_ack) begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // only the pin reset loads the initial value; watchdog reset is ignored here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      freq_control_reg <= cms_pkg::FREQ_CTRL_RESET;
    end else if (do_write) begin
      freq_control_reg <= next_freq;
    end
  end

  // bus clock pin input synchroniser, for status only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_in_meta <= 1'b0;
      bus_in_sync <= 1'b0;
    end else begin
      bus_in_meta <= bus_clock_io_in;
      bus_in_sync <= bus_in_meta;
    end
  end

  // pin toggles when running, stays low when held
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_clk_level <= 1'b0;
    end else if (next_bus_oe && !bus_hold) begin
      bus_clk_level <= !bus_clk_level;
    end else begin
      bus_clk_level <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_clock_io_out <= 1'b0;
      bus_clock_io_oe <= 1'b0;
      clock_mode <= 3'h0;
      mode_valid <= 1'b0;
      mode_illegal <= 1'b0;
      crystal_osc_enable <= 1'b0;
      ext_clock_select <= 1'b0;
      pll2_enable <= 1'b0;
      pll2_ratio_x4 <= 1'b0;
      pll1_enable <= 1'b0;
      pll1_ratio <= 2'h0;
      pll1_ref_bus_clock <= 1'b0;
      pll_standby <= 1'b0;
      div1_src_pll1 <= 1'b0;
      div2_src_pll1 <= 1'b0;
      div3_enable <= 1'b0;
      internal_div <= 2'h0;
      periph_div <= 2'h0;
    end else begin
      bus_clock_io_out <= bus_clk_level;
      bus_clock_io_oe <= next_bus_oe;
      clock_mode <= mode;
      mode_valid <= strap_valid;
      mode_illegal <= strap_illegal;
      crystal_osc_enable <= next_crystal_drive_out;
      ext_clock_select <= next_ext;
      pll2_enable <= strap_valid && !m_bus_in;
      pll2_ratio_x4 <= next_pll2_x4;
      pll1_enable <= next_pll1_en;
      pll1_ratio <= freq_control_reg[cms_pkg::POS_PLL1_RATIO +: 2];
      // PLL1 feedback taken from the bus clock pin
      pll1_ref_bus_clock <= next_pll1_en;
      pll_standby <= freq_control_reg[cms_pkg::BIT_PLL_STANDBY];
      // dividers fall back to PLL2 while PLL1 is off
      div1_src_pll1 <= next_pll1_en;
      div2_src_pll1 <= next_pll1_en && !m_sw_pll1;
      div3_enable <= 1'b0;
      internal_div <= freq_control_reg[cms_pkg::POS_INT_DIV +: 2];
      periph_div <= freq_control_reg[cms_pkg::POS_PER_DIV +: 2];
    end
  end
endmodule : cms_clock_mode_ctrl

/* File: rtl/cms_pkg.sv */
// constants shared by the clock mode select controller
package cms_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_FREQ_CTRL = 32'hFFFF_FF80;
  localparam logic [31:0] ADDR_MODE_STATUS = 32'hFFFF_FF84;
  // freq_control_reg reset value and field positions
  localparam logic [15:0] FREQ_CTRL_RESET = 16'h0102;
  localparam int BIT_BUS_CLK_OUT = 8;
  localparam int BIT_PLL_STANDBY = 7;
  localparam int BIT_PLL1_ON = 6;
  localparam int POS_PLL1_RATIO = 4;
  localparam int POS_INT_DIV = 2;
  localparam int POS_PER_DIV = 0;
  // mode status field positions
  localparam int POS_ST_MODE = 0;
  localparam int BIT_ST_VALID = 3;
  localparam int BIT_ST_ILLEGAL = 4;
  localparam int BIT_ST_PLL1 = 5;
  localparam int BIT_ST_BUS_OE = 6;
  localparam int BIT_ST_BUS_IN = 7;
  // cycles after reset release before straps are taken
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
  typedef enum logic [2:0] {
    CMS_MODE0 = 3'b000,
    CMS_MODE1 = 3'b001,
    CMS_MODE2 = 3'b010,
    CMS_MODE3 = 3'b011,
    CMS_MODE4 = 3'b100,
    CMS_MODE5 = 3'b101,
    CMS_MODE6 = 3'b110,
    CMS_MODE7 = 3'b111
  } cms_mode_t;
endpackage : cms_pkg

/* File: rtl/cms_strap_capture.sv */
// mode strap synchroniser, capture and decode
`timescale 1ns/100ps
module cms_strap_capture (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic recapture,
  // strap pins
  input wire logic mode_strap_bit0,
  input wire logic mode_strap_bit1,
  input wire logic mode_strap_bit2,
  // decoded mode
  output cms_pkg::cms_mode_t mode,
  output logic mode_valid,
  output logic mode_illegal
);
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic [1:0] settle;
  logic taken;
  wire take_now = (settle == cms_pkg::STRAP_SETTLE_CYCLES) && !taken;
  // 101 and 110 are no defined mode
  wire strap_bad = (strap_sync == 3'h5) || (strap_sync == 3'h6);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end else begin
      strap_meta <= {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0};
      strap_sync <= strap_meta;
    end
  end

  // straps are caught by a clocked process after release, never by the reset itself
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle <= 2'h0;
      taken <= 1'b0;
      mode <= cms_pkg::CMS_MODE0;
      mode_valid <= 1'b0;
      mode_illegal <= 1'b0;
    end else if (recapture) begin
      settle <= 2'h0;
      taken <= 1'b0;
      mode_valid <= 1'b0;
    end else if (take_now) begin
      taken <= 1'b1;
      mode <= cms_pkg::cms_mode_t'(strap_sync);
      mode_valid <= !strap_bad;
      mode_illegal <= strap_bad;
    end else if (!taken) begin
      settle <= settle + 2'h1;
    end
  end
endmodule : cms_strap_capture

/* File: test/cms_clock_mode_monitor.sv */
// port assertions for the clock mode controller
`timescale 1ns/100ps
module cms_clock_mode_monitor (
  // clock, reset and bus handshake
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // clock generator controls
  input wire logic [2:0] clock_mode,
  input wire logic mode_valid,
  input wire logic crystal_osc_enable,
  input wire logic pll2_enable,
  input wire logic pll2_ratio_x4,
  input wire logic pll1_enable,
  input wire logic div1_src_pll1,
  input wire logic div3_enable,
  input wire logic bus_clock_io_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // derived outputs register on the same edge as mode_valid; checks start one edge later
  sequence s_st; mode_valid && $past(mode_valid); endsequence
  property p_oe; s_st |-> bus_clock_io_oe == (clock_mode != 3'h7); endproperty
  a_oe: assert property (p_oe) else $error("bad oe");
  property p_xt; s_st |-> crystal_osc_enable == (clock_mode inside {3'h2, 3'h4}); endproperty
  a_xt: assert property (p_xt) else $error("bad crystal");
  property p_x4; s_st |-> pll2_ratio_x4 == (clock_mode inside {3'h1, 3'h2}); endproperty
  a_x4: assert property (p_x4) else $error("bad ratio");
  property p_p2; s_st |-> pll2_enable == (clock_mode != 3'h7); endproperty
  a_p2: assert property (p_p2) else $error("bad pll2");
  property p_p1; s_st and !(clock_mode inside {3'h3, 3'h4}) |-> pll1_enable; endproperty
  a_p1: assert property (p_p1) else $error("bad pll1");
  property p_dv; s_st |-> div1_src_pll1 == pll1_enable; endproperty
  a_dv: assert property (p_dv) else $error("bad divider");
  property p_d3; !div3_enable; endproperty
  a_d3: assert property (p_d3) else $error("bad div3");
  property p_bus; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
  a_bus: assert property (p_bus) else $error("bad handshake");
endmodule : cms_clock_mode_monitor
bind cms_clock_mode_ctrl cms_clock_mode_monitor i_mon (.clk_sys, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .clock_mode, .mode_valid, .crystal_osc_enable, .pll2_enable, .pll2_ratio_x4, .pll1_enable, .div1_src_pll1,
  .div3_enable, .bus_clock_io_oe);

/* File: test/cms_board_model.sv */
// board model: mode straps and the shared bus clock wire
`timescale 1ns/100ps
module cms_board_model (
  // bench selection
  input wire logic [2:0] strap_sel,
  // bus clock pin, device side
  input wire logic bus_clock_io_out,
  input wire logic bus_clock_io_oe,
  // board side
  output logic [2:0] straps,
  output logic bus_clock_io_in
);
  logic ext_clk = 1'b0;
  assign straps = (strap_sel inside {3'h5, 3'h6}) ? 3'h0 : strap_sel;
  always #3 ext_clk = ~ext_clk;
  // board clock feeds an undriven pin
  assign bus_clock_io_in = bus_clock_io_oe ? bus_clock_io_out : ext_clk;
endmodule : cms_board_model

/* File: test/cms_clock_mode_ctrl_test.sv */
// self-checking bench for the clock mode controller
`timescale 1ns/100ps
module cms_clock_mode_ctrl_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wdt = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] adr = 32'h0000_0000;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata, q;
  logic [2:0] sel = 3'h0;
  logic [2:0] straps, cm;
  logic [1:0] r1, idv, pdv;
  logic wreq, bio, bout, boe, mv, cry, ext, p2, x4, p1, sb, d1, d2, d3, t, il, rf;
  logic [3:0] be = 4'hf;
  logic [10:0] want;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
  int errors = 0;
  int checks = 0;
  always #2 clk_sys = ~clk_sys;
  cms_board_model i_board (.strap_sel(sel), .bus_clock_io_out(bout), .bus_clock_io_oe(boe), .straps(straps),
    .bus_clock_io_in(bio));
  cms_clock_mode_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wdt_poweron_reset(wdt),
    .mode_strap_bit0(straps[0]), .mode_strap_bit1(straps[1]), .mode_strap_bit2(straps[2]),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .bus_clock_io_in(bio), .bus_clock_io_out(bout),
    .bus_clock_io_oe(boe), .clock_mode(cm), .mode_valid(mv), .mode_illegal(il), .crystal_osc_enable(cry),
    .ext_clock_select(ext), .pll2_enable(p2), .pll2_ratio_x4(x4), .pll1_enable(p1), .pll1_ratio(r1),
    .pll1_ref_bus_clock(rf), .pll_standby(sb), .div1_src_pll1(d1), .div2_src_pll1(d2), .div3_enable(d3),
    .internal_div(idv), .periph_div(pdv));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic limit(input int n);
    if (n >= 20) begin
      errors++;
      tally_and_finish();
    end
  endtask : limit
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    limit(n);
  endtask : bus
  // a watchdog pulse leaves mode_valid high for one more edge: wait for it to drop first
  task automatic settle;
    int n;
    n = 0;
    while (mv !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    limit(n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (mv !== 1'b1 && n < 20);
    repeat (2) @(posedge clk_sys);
    limit(n);
  endtask : settle
  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
  endtask : reset_dut
  // {crystal, ext, x4, pll1, div1, div2, oe, pll2, div3}
  function automatic logic [8:0] want_of(input logic [2:0] m);
    logic f;
    f = m inside {3'h3, 3'h4};
    return {m inside {3'h2, 3'h4}, m inside {3'h0, 3'h1, 3'h3}, m inside {3'h1, 3'h2}, !f, !f, !f,
      m != 3'h7, m != 3'h7, 1'b0};
  endfunction : want_of
  initial begin
    for (int i = 0; i < 6; i++) begin
      sel <= modes[i];
      reset_dut();
      chk("mode", cm, modes[i]);
      want = {want_of(modes[i]), 1'b0, !(modes[i] inside {3'h3, 3'h4})};
      chk("controls", {cry, ext, x4, p1, d1, d2, boe, p2, d3, il, rf}, want);
      // pin sample bit depends on clock phase, so it is masked
      bus(1'b0, cms_pkg::ADDR_MODE_STATUS, 32'h0000_0000);
      want = {4'h0, modes[i] != 3'h7, !(modes[i] inside {3'h3, 3'h4}), 1'b0, 1'b1, modes[i]};
      chk("status", q & 32'h0000_007f, want);
    end
    bus(1'b0, cms_pkg::ADDR_FREQ_CTRL, 32'h0000_0000);
    chk("freq reset", q, 32'h0000_0102);
    @(posedge clk_sys);
    t = bout;
    @(posedge clk_sys);
    chk("toggle", t ^ bout, 32'h0000_0001);
    bus(1'b1, cms_pkg::ADDR_FREQ_CTRL, 32'h0000_01e9);
    repeat (2) @(posedge clk_sys);
    chk("pll1 on", {rf, p1, d1, d2, sb, r1, idv, pdv}, 32'h0000_0769);
    bus(1'b0, cms_pkg::ADDR_FREQ_CTRL, 32'h0000_0000);
    chk("readback", q, 32'h0000_01e9);
    bus(1'b0, 32'hffff_ff88, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    @(posedge clk_sys);
    wdt <= 1'b1;
    @(posedge clk_sys);
    wdt <= 1'b0;
    settle();
    bus(1'b0, cms_pkg::ADDR_FREQ_CTRL, 32'h0000_0000);
    chk("wdt keeps", q, 32'h0000_01e9);
    chk("wdt mode", {cm, p1}, {3'h4, 1'b1});
    // only lane 1 written: clears the running bit, lane 0 and upper bits ignored
    be <= 4'h2;
    bus(1'b1, cms_pkg::ADDR_FREQ_CTRL, 32'h5a5a_00ff);
    be <= 4'hf;
    bus(1'b0, cms_pkg::ADDR_FREQ_CTRL, 32'h0000_0000);
    chk("lanes", q, 32'h0000_00e9);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      chk("held", {boe, bout}, 32'h0000_0002);
    end
    reset_dut();
    bus(1'b0, cms_pkg::ADDR_FREQ_CTRL, 32'h0000_0000);
    chk("pin reset", q, 32'h0000_0102);
    tally_and_finish();
  end
endmodule : cms_clock_mode_ctrl_test
